// file: hdl/ubw_pkg.sv
// shared constants and types of the break wake-up receiver
package ubw_pkg;

    // register byte offsets
    localparam logic [7:0]  ADDR_BAUD  = 8'h00;
    localparam logic [7:0]  ADDR_CTRL  = 8'h04;
    localparam logic [7:0]  ADDR_STAT  = 8'h08;
    localparam logic [7:0]  ADDR_DATA  = 8'h0C;
    localparam logic [7:0]  ADDR_DIV   = 8'h10;

    // field positions
    localparam int          BIT_WAKE   = 1;
    localparam int          BIT_IDLE   = 6;
    localparam int          BIT_SYNC   = 0;
    localparam int          BIT_RXEN   = 1;
    localparam int          BIT_INT    = 0;
    localparam int          BIT_OVR    = 1;
    localparam int          BIT_FERR   = 2;

    // values after reset
    localparam logic        WAKE_RST   = 1'b0;
    localparam logic        SYNC_RST   = 1'b0;
    localparam logic        RXEN_RST   = 1'b0;
    localparam logic [15:0] DIV_RST    = 16'h0411;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

    // widths and counts
    localparam int          DATA_W     = 8;
    localparam int          FIFO_DEPTH = 4;
    localparam logic [2:0]  LAST_BIT   = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b10,
        ST_STOP  = 2'b11
    } ubw_state_t;

endpackage

// file: hdl/ubw_sync.sv
// two-flop synchroniser for the receive pin
`timescale 1ns/1ps
module ubw_sync
    import ubw_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta;

    // line idles high, so reset to high avoids a false falling edge
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta   <= 1'b1;
            sync_o <= 1'b1;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// file: hdl/ubw_fifo.sv
// small receive fifo with valid/ready on both sides
`timescale 1ns/1ps
module ubw_fifo
    import ubw_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (count != AW'(0) + (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count  <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: hdl/ubw_detector.sv
// serial receiver with break wake-up detection and apb registers
`timescale 1ns/1ps
module ubw_detector
    import ubw_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        serial_rx_line_i,
    input  wire logic        sleep_i,
    output logic             rx_int_o
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // register state
    logic        wake_enable;
    logic        wake_seen;
    logic        wake_flag;
    logic        sync_mode;
    logic        rx_enable;
    logic        overrun;
    logic        frame_err;
    logic [15:0] divisor;

    // receiver state
    ubw_state_t  st;
    ubw_state_t  next_st;
    logic        half;
    logic        next_half;
    logic [2:0]  bit_cnt;
    logic [2:0]  next_bit_cnt;
    logic [7:0]  shreg;
    logic [7:0]  next_shreg;
    logic [15:0] div_cnt;
    logic        rx_prev;
    logic        rx_s;
    logic        push;
    logic        push_ok;
    logic        push_bad;

    // fifo side
    logic        fifo_in_ready;
    logic        fifo_valid;
    logic [7:0]  fifo_data;

    ubw_sync u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .async_i (serial_rx_line_i),
        .sync_o  (rx_s)
    );

    // apb decode
    wire acc       = psel_i & penable_i;
    wire setup     = psel_i & ~penable_i;
    wire wr        = acc & pwrite_i;
    wire rd        = acc & ~pwrite_i;
    wire hit_baud  = hit(paddr_i, ADDR_BAUD);
    wire hit_ctrl  = hit(paddr_i, ADDR_CTRL);
    wire hit_stat  = hit(paddr_i, ADDR_STAT);
    wire hit_data  = hit(paddr_i, ADDR_DATA);
    wire hit_div   = hit(paddr_i, ADDR_DIV);
    wire mapped    = hit_baud | hit_ctrl | hit_stat | hit_data | hit_div;
    wire wue_wr    = wr & hit_baud;
    wire ctrl_wr   = wr & hit_ctrl;
    wire stat_wr   = wr & hit_stat;
    wire div_wr    = wr & hit_div;
    wire data_read = rd & hit_data;

    assign pready_o  = 1'b1;
    assign pslverr_o = acc & ~mapped;

    // line edges
    wire fall = rx_prev & ~rx_s;
    wire rise = ~rx_prev & rx_s;

    // wake-up tracking
    wire wake_event = wake_enable & ~wake_seen & fall;
    wire wake_end   = wake_enable & wake_seen & rise;
    wire idle_bit   = (st == ST_IDLE);

    // a software write in the same cycle as the end of break takes priority
    wire next_wake_enable = sync_mode ? 1'b0 :
                            wue_wr    ? pwdata_i[BIT_WAKE] :
                            wake_end  ? 1'b0 :
                                        wake_enable;
    wire next_wake_seen   = wake_enable & next_wake_enable & (wake_seen | fall);
    // set wins over the clear by a read
    wire next_wake_flag   = wake_event | (wake_flag & ~data_read);

    // awake: registered flag; asleep: the event passes without a clock edge
    assign rx_int_o = wake_flag | fifo_valid | (sleep_i & wake_event);

    // bit-rate divider, one pulse per half bit; halted in sleep
    wire baud_run  = rx_enable & ~sleep_i & ~sync_mode & (st != ST_IDLE);
    wire baud_tick = baud_run & (div_cnt == divisor);
    wire start_ok  = rx_enable & ~sync_mode & ~sleep_i & ~wake_enable;

    always_comb begin
        next_st      = st;
        next_half    = half;
        next_bit_cnt = bit_cnt;
        next_shreg   = shreg;
        push_ok      = 1'b0;
        push_bad     = 1'b0;
        case (st)
            ST_IDLE: begin
                if (start_ok && fall) begin
                    next_st   = ST_START;
                    next_half = 1'b0;
                end
            end
            ST_START: begin
                if (baud_tick) begin
                    next_st      = rx_s ? ST_IDLE : ST_DATA;
                    next_half    = 1'b0;
                    next_bit_cnt = 3'h0;
                end
            end
            ST_DATA: begin
                if (baud_tick) begin
                    next_half = ~half;
                    if (half) begin
                        next_shreg   = {rx_s, shreg[7:1]};
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == LAST_BIT) begin
                            next_st = ST_STOP;
                        end
                    end
                end
            end
            ST_STOP: begin
                if (baud_tick) begin
                    next_half = ~half;
                    if (half) begin
                        next_st  = ST_IDLE;
                        push_ok  = rx_s;
                        push_bad = ~rx_s;
                    end
                end
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
        if (wake_enable) begin
            next_st  = ST_IDLE;
            push_ok  = 1'b0;
            push_bad = 1'b0;
        end
    end

    assign push = push_ok;

    ubw_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (shreg),
        .out_valid_o (fifo_valid),
        .out_ready_i (data_read),
        .out_data_o  (fifo_data)
    );

    // empty fifo reads zero, which covers the dummy byte after a wake event
    wire [31:0] rd_baud = {25'h0, idle_bit, 4'h0, wake_enable, 1'b0};
    wire [31:0] rd_ctrl = {30'h0, rx_enable, sync_mode};
    wire [31:0] rd_stat = {29'h0, frame_err, overrun, wake_flag | fifo_valid};
    wire [31:0] rd_data = {24'h0, fifo_valid ? fifo_data : 8'h00};
    wire [31:0] rd_div  = {16'h0, divisor};
    wire [31:0] next_prdata = hit_baud ? rd_baud :
                              hit_ctrl ? rd_ctrl :
                              hit_stat ? rd_stat :
                              hit_data ? rd_data :
                              hit_div  ? rd_div  : 32'h0000_0000;

    // flags clear on writing one; a new error in the same cycle wins
    wire next_overrun   = (push & ~fifo_in_ready) | (overrun & ~(stat_wr & pwdata_i[BIT_OVR]));
    wire next_frame_err = push_bad | (frame_err & ~(stat_wr & pwdata_i[BIT_FERR]));

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wake_enable <= WAKE_RST;
            wake_seen   <= 1'b0;
            wake_flag   <= 1'b0;
            overrun     <= 1'b0;
            frame_err   <= 1'b0;
            prdata_o    <= PRDATA_RST;
        end else begin
            wake_enable <= next_wake_enable;
            wake_seen   <= next_wake_seen;
            wake_flag   <= next_wake_flag;
            overrun     <= next_overrun;
            frame_err   <= next_frame_err;
            if (setup) begin
                prdata_o <= next_prdata;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync_mode <= SYNC_RST;
            rx_enable <= RXEN_RST;
            divisor   <= DIV_RST;
        end else begin
            if (ctrl_wr) begin
                sync_mode <= pwdata_i[BIT_SYNC];
                rx_enable <= pwdata_i[BIT_RXEN];
            end
            if (div_wr) begin
                divisor <= pwdata_i[15:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st      <= ST_IDLE;
            half    <= 1'b0;
            bit_cnt <= 3'h0;
            shreg   <= 8'h00;
            div_cnt <= 16'h0000;
            rx_prev <= 1'b1;
        end else begin
            st      <= next_st;
            half    <= next_half;
            bit_cnt <= next_bit_cnt;
            shreg   <= next_shreg;
            div_cnt <= (!baud_run || baud_tick) ? 16'h0000 : div_cnt + 16'h0001;
            rx_prev <= rx_s;
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_SLEEP_HALT: assert property (
        sleep_i |-> !baud_tick ##1 div_cnt == 16'h0000)
        else $error("divider ran during sleep");

    AST_SYNC_NO_WAKE: assert property (
        sync_mode |=> !wake_enable)
        else $error("wake enable stayed set in sync mode");

    AST_WUE_SET: assert property (
        wue_wr && pwdata_i[BIT_WAKE] && !sync_mode |=> wake_enable)
        else $error("write of wake enable not taken");

    AST_WAKE_IDLE: assert property (
        wake_enable |=> st == ST_IDLE && !push)
        else $error("reception ran while wake armed");

    AST_FALL_FLAG: assert property (
        wake_enable && !wake_seen && fall && next_wake_enable |=> wake_flag && wake_seen)
        else $error("falling edge did not register a wake event");

    AST_FLAG_INT: assert property (
        wake_flag |-> rx_int_o)
        else $error("wake flag not signalled");

    AST_SLEEP_INT: assert property (
        sleep_i && wake_event |-> rx_int_o ##1 wake_flag)
        else $error("sleep interrupt missing");

    AST_READ_CLR: assert property (
        data_read && !wake_event |=> !wake_flag)
        else $error("data read did not clear wake flag");

    AST_RISE_CLR: assert property (
        wake_end && !wue_wr |=> !wake_enable ##1 !wake_seen)
        else $error("rising edge did not end wake");

    AST_IDLE_STAT: assert property (
        setup && hit_baud |=> prdata_o[BIT_IDLE] == $past(idle_bit))
        else $error("idle status read wrong");

    AST_NORMAL_START: assert property (
        st == ST_IDLE && start_ok && fall |=> st == ST_START)
        else $error("falling edge did not start a byte");

endmodule

// file: tb/ubw_tx_model.sv
// remote serial transmitter model that drives the receive line
`timescale 1ns/1ps
module ubw_tx_model #(
    parameter int BIT_CLKS = 8
)(
    input  wire logic clk_i,
    output logic      line_o
);
    // idle high between frames, as the line is pulled up
    initial line_o = 1'b1;

    // hold a level for whole bit times; the level changes just after an edge
    task automatic hold(input logic v, input int bits);
        @(posedge clk_i);
        line_o <= v;
        repeat (bits * BIT_CLKS - 1) @(posedge clk_i);
    endtask

    // a break or wake-up character begins by pulling the line low
    task automatic start_low();
        @(posedge clk_i);
        line_o <= 1'b0;
    endtask

    // start bit, eight data bits lsb first, then two stop bit times
    task automatic send_byte(input logic [7:0] b);
        hold(1'b0, 1);
        for (int i = 0; i < 8; i++) begin
            hold(b[i], 1);
        end
        hold(1'b1, 2);
    endtask
endmodule

// file: tb/uart_break_wakeup_detector_test.sv
// self-checking bench of the break wake-up receiver
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module uart_break_wakeup_detector_test;
    import ubw_pkg::*;
    logic        clk_i     = 1'b0;
    logic        reset_i   = 1'b1;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0;
    logic        sleep_i   = 1'b0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        rx_int_o;
    logic        rx_line;
    logic [31:0] rd;
    logic        err;
    int          num_errors = 0;
    int          checks     = 0;
    int          cycles     = 0;
    int          n;

    always #25 clk_i = ~clk_i;

    ubw_detector u_ubw_detector (
        .clk_i            (clk_i),
        .reset_i          (reset_i),
        .psel_i           (psel_i),
        .penable_i        (penable_i),
        .pwrite_i         (pwrite_i),
        .paddr_i          (paddr_i),
        .pwdata_i         (pwdata_i),
        .prdata_o         (prdata_o),
        .pready_o         (pready_o),
        .pslverr_o        (pslverr_o),
        .serial_rx_line_i (rx_line),
        .sleep_i          (sleep_i),
        .rx_int_o         (rx_int_o)
    );

    // divisor 3 gives 8 clocks a bit
    ubw_tx_model #(.BIT_CLKS(8)) u_ubw_tx_model (
        .clk_i  (clk_i),
        .line_o (rx_line)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // the whole run needs about 1150 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, exp, rd)
    endtask

    // edges from the falling line to a raised interrupt
    task automatic count_int(output int k);
        k = 0;
        do begin
            @(posedge clk_i);
            #1;
            k++;
        end while (rx_int_o !== 1'b1 && k < 20);
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        rdchk(ADDR_BAUD, 32'h0000_0040, "baud rst");
        rdchk(ADDR_CTRL, 32'h0, "ctrl rst");
        rdchk(ADDR_DIV, {16'h0, DIV_RST}, "div rst");
        rdchk(8'h14, 32'h0, "unmapped");
        `CHK("slverr", 1'b1, err)
        apb(1'b1, ADDR_DIV, 32'h3);
        apb(1'b1, ADDR_CTRL, 32'h2);
        u_ubw_tx_model.send_byte(8'hA5);
        rdchk(ADDR_DATA, 32'hA5, "plain byte");
        // wake-up while awake
        apb(1'b1, ADDR_BAUD, 32'h2);
        rdchk(ADDR_BAUD, 32'h0000_0042, "armed");
        u_ubw_tx_model.start_low();
        count_int(n);
        `CHK("awake latency", 3, n)
        u_ubw_tx_model.hold(1'b0, 12);
        apb(1'b0, ADDR_BAUD, 32'h0);
        `CHK("wake held", 1'b1, rd[BIT_WAKE])
        u_ubw_tx_model.hold(1'b1, 2);
        apb(1'b0, ADDR_BAUD, 32'h0);
        `CHK("wake cleared", 1'b0, rd[BIT_WAKE])
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK("flag", 1'b1, rd[BIT_INT])
        apb(1'b0, ADDR_DATA, 32'h0);
        @(posedge clk_i);
        `CHK("int dropped", 1'b0, rx_int_o)
        // idle status must read low while a byte is on its way in
        fork
            u_ubw_tx_model.send_byte(8'h3C);
            begin
                repeat (20) @(posedge clk_i);
                rdchk(ADDR_BAUD, 32'h0, "busy idle");
            end
        join
        rdchk(ADDR_DATA, 32'h3C, "byte after wake");
        // sleep: no reception, wake passes straight through
        sleep_i <= 1'b1;
        u_ubw_tx_model.send_byte(8'h55);
        repeat (4) @(posedge clk_i);
        `CHK("sleep rx", 1'b0, rx_int_o)
        apb(1'b1, ADDR_BAUD, 32'h2);
        u_ubw_tx_model.start_low();
        count_int(n);
        `CHK("sleep latency", 2, n)
        u_ubw_tx_model.hold(1'b0, 12);
        u_ubw_tx_model.hold(1'b1, 2);
        sleep_i <= 1'b0;
        apb(1'b0, ADDR_BAUD, 32'h0);
        `CHK("sleep wake clr", 1'b0, rd[BIT_WAKE])
        apb(1'b0, ADDR_DATA, 32'h0);
        // synchronous mode refuses the wake-up feature
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b1, ADDR_BAUD, 32'h2);
        apb(1'b0, ADDR_BAUD, 32'h0);
        `CHK("sync wake", 1'b0, rd[BIT_WAKE])
        apb(1'b1, ADDR_CTRL, 32'h2);
        // five bytes into four places: the last is dropped
        for (int i = 1; i <= 5; i++) begin
            u_ubw_tx_model.send_byte(8'(i * 8'h11));
        end
        `CHK("int fifo", 1'b1, rx_int_o)
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK("overrun", 1'b1, rd[BIT_OVR])
        for (int i = 1; i <= 4; i++) begin
            rdchk(ADDR_DATA, 32'(i * 8'h11), "fifo order");
        end
        rdchk(ADDR_DATA, 32'h0, "fifo empty");
        @(posedge clk_i);
        `CHK("int empty", 1'b0, rx_int_o)
        apb(1'b1, ADDR_STAT, 32'h2);
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK("overrun clr", 1'b0, rd[BIT_OVR])
        // a low stop bit is a framing error; the byte is not kept
        u_ubw_tx_model.hold(1'b0, 10);
        u_ubw_tx_model.hold(1'b1, 2);
        rdchk(ADDR_STAT, 32'h4, "frame err");
        apb(1'b1, ADDR_STAT, 32'h4);
        rdchk(ADDR_STAT, 32'h0, "frame err clr");
        give_verdict();
    end
endmodule
